// *** bench/rflw_assertions.sv ***
// Checker for the release block: register port and port 1 flow control.
// Assumes binding onto rflw_top; shadows the port 1 threshold itself.
module rflw_assertions
(
  // Clock and reset
  input wire logic                                                  clock,
  input wire logic                                                  reset,
  // Register port
  input wire logic [rflw_pkg::ADDR_W-1:0]                           reg_addr,
  input wire logic [rflw_pkg::DATA_W-1:0]                           reg_wdata,
  input wire logic                                                  reg_write,
  input wire logic                                                  reg_read,
  input wire logic [rflw_pkg::DATA_W-1:0]                           reg_rdata,
  // Occupancy, watermarks and requests
  input wire logic [rflw_pkg::NUM_PORTS-1:0][rflw_pkg::FILL_W-1:0] fill_level,
  input wire logic [rflw_pkg::NUM_PORTS-1:0][rflw_pkg::THR_W-1:0]  high_thr,
  input wire logic [rflw_pkg::NUM_PORTS-1:0]                        flow_req
);
  logic [11:0] lo_q;

  // Shadow of the port 1 release threshold
  always_ff @(posedge clock)
    if (reset)
      lo_q <= rflw_pkg::THR_RESET;
    else if (reg_write && reg_addr == 12'h58b)
      lo_q <= reg_wdata[11:0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_raise; fill_level[0] > high_thr[0] |=> flow_req[0]; endproperty
  a_raise: assert property (p_raise) else $error("raise missing");
  property p_rel; fill_level[0] < lo_q && fill_level[0] <= high_thr[0] |=> !flow_req[0]; endproperty
  a_rel: assert property (p_rel) else $error("release missing");
  property p_hold; fill_level[0] >= lo_q && fill_level[0] <= high_thr[0] |=> $stable(flow_req[0]); endproperty
  a_hold: assert property (p_hold) else $error("request moved in band");
  property p_rdthr; reg_read && reg_addr == 12'h58b |=> reg_rdata == {20'h00000, $past(lo_q)}; endproperty
  a_rdthr: assert property (p_rdthr) else $error("threshold readback wrong");
  property p_unmap; reg_read && reg_addr == 12'h58a |=> reg_rdata == 32'h00000000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_upper; reg_read |=> reg_rdata[31:12] == 20'h00000; endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero");
  property p_idle; !reg_read |=> reg_rdata == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data not cleared");
endmodule : rflw_assertions

bind rflw_top rflw_assertions u_chk (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .fill_level(fill_level),
  .high_thr(high_thr), .flow_req(flow_req));

// *** bench/rflw_tb_top.sv ***
// Self-checking bench for the release block.
// Assumes the checker is bound in; bench drives every port itself.
module rflw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clock, reset, reg_write, reg_read;
  logic [11:0]      reg_addr;
  logic [31:0]      reg_wdata, reg_rdata;
  logic [2:0][12:0] fill_level;
  logic [2:0][11:0] high_thr, lo;
  logic [2:0]       flow_req, m;
  logic [12:0]      f;
  int               err_total, comparisons, p;

  rflw_top uut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .fill_level(fill_level),
    .high_thr(high_thr), .flow_req(flow_req));

  // Free-running 4 ns clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task check(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check

  // Flow-control request compare, all three ports at once
  task check_req(logic [2:0] e, logic [2:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR flow_req expected %h seen %h", e, g);
    end
  endtask : check_req

  task wr(logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task rd(logic [11:0] a, logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    check("reg_rdata", e, reg_rdata);
  endtask : rd

  // Hysteresis reference: raise wins, then release, else hold
  function logic fc(logic s, logic [12:0] x, logic [11:0] l, logic [11:0] h);
    return (x > h) ? 1'b1 : (x < l) ? 1'b0 : s;
  endfunction : fc

  task report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Reset, register checks, then random occupancy around the band
  initial
  begin
    {reset, reg_write, reg_read, reg_addr, reg_wdata, fill_level, high_thr} = '0;
    reset = 1'b1;
    void'($urandom(32'h70e2));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    for (p = 0; p < 3; p++) rd(12'h58b + 12'(p), 32'h00000072);
    rd(12'h58a, 32'h00000000);
    for (p = 0; p < 3; p++)
    begin
      lo[p] = 12'd4 + 12'($urandom % 200);
      wr(12'h58b + 12'(p), ($urandom & 32'hfffff000) | {20'h00000, lo[p]});
    end
    for (p = 0; p < 3; p++) rd(12'h58b + 12'(p), {20'h00000, lo[p]});
    @(posedge clock);
    for (p = 0; p < 3; p++) high_thr[p] <= lo[p] + 12'd1 + 12'($urandom % 8);
    m = 3'h0;
    repeat (400)
    begin
      @(negedge clock);
      check_req(m, flow_req);
      @(posedge clock);
      for (p = 0; p < 3; p++)
      begin
        // Model the occupancy the design samples at this very edge
        m[p] = fc(m[p], fill_level[p], lo[p], high_thr[p]);
        f = 13'(lo[p]) - 13'd3 + 13'($urandom % (high_thr[p] - lo[p] + 7));
        fill_level[p] <= f;
      end
    end
    // Last occupancy is taken at the next edge, before the status read
    @(negedge clock);
    for (p = 0; p < 3; p++) m[p] = fc(m[p], fill_level[p], lo[p], high_thr[p]);
    rd(12'h5a0, {29'h0, m});
    // Mid-run reset restores thresholds and drops the requests
    @(posedge clock);
    reset      <= 1'b1;
    fill_level <= '0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (p = 0; p < 3; p++) rd(12'h58b + 12'(p), 32'h00000072);
    check_req(3'h0, flow_req);
    report_and_stop;
  end
endmodule : rflw_tb_top

// *** verilog/rflw_pkg.sv ***
// Package for the receive FIFO low watermark release block.
// Assumes one core clock domain and word-indexed register addresses.
package rflw_pkg;

  // Port count and widths
  localparam int unsigned NUM_PORTS    = 3;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned THR_W        = 12;
  localparam int unsigned FILL_W       = 13;

  // One threshold count is one FIFO location of this many bytes
  localparam int unsigned LOC_BYTES    = 8;

  // Register indices (word addresses)
  localparam logic [11:0] RX_RELEASE_THRESHOLD_PORT1 = 12'h58b;
  localparam logic [11:0] RX_RELEASE_THRESHOLD_PORT2 = 12'h58c;
  localparam logic [11:0] RX_RELEASE_THRESHOLD_PORT3 = 12'h58d;
  localparam logic [11:0] RX_FLOW_STATUS             = 12'h5a0;

  // Field layout
  localparam int unsigned THR_LSB      = 0;
  localparam int unsigned THR_MSB      = 11;
  localparam int unsigned STATUS_LSB   = 0;

  // Reset value of each threshold, 114 locations
  localparam logic [11:0] THR_RESET    = 12'h072;

  // Per-port flow-control state
  typedef enum logic
  {
    RFLW_FC_OPEN = 1'b0,
    RFLW_FC_HOLD = 1'b1
  } rflw_fc_state_t;

endpackage : rflw_pkg

// *** verilog/rflw_port_ctl.sv ***
// Hysteresis flow-control state for one receive port.
// Assumes occupancy and thresholds are synchronous to clock.
module rflw_port_ctl
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // Occupancy and thresholds in 8-byte locations
  input  wire logic [rflw_pkg::FILL_W-1:0] fill_level,
  input  wire logic [rflw_pkg::THR_W-1:0]  low_thr,
  input  wire logic [rflw_pkg::THR_W-1:0]  high_thr,
  // Flow-control request
  output logic                             flow_req
);

  rflw_pkg::rflw_fc_state_t state_q;
  rflw_pkg::rflw_fc_state_t state_d;
  logic [rflw_pkg::FILL_W-1:0] low_ext;
  logic [rflw_pkg::FILL_W-1:0] high_ext;

  // Thresholds widened to occupancy width, same location units
  assign low_ext  = {1'b0, low_thr};   // [RL1]
  assign high_ext = {1'b0, high_thr};  // [RL1]

  // Next state: raise above high, release below low, else hold
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rflw_pkg::RFLW_FC_OPEN:
      begin
        if (fill_level > high_ext)
        begin
          state_d = rflw_pkg::RFLW_FC_HOLD;  // [RL6]
        end
      end
      rflw_pkg::RFLW_FC_HOLD:
      begin
        // Raise wins if software set low above high
        if ((fill_level < low_ext) && !(fill_level > high_ext))
        begin
          state_d = rflw_pkg::RFLW_FC_OPEN;  // [RL2]
        end
      end
      default:
      begin
        state_d = rflw_pkg::RFLW_FC_OPEN;
      end
    endcase
  end

  // State register; inside the band nothing changes
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= rflw_pkg::RFLW_FC_OPEN;
    end
    else
    begin
      state_q <= state_d;  // [RL7]
    end
  end

  assign flow_req = (state_q == rflw_pkg::RFLW_FC_HOLD);

endmodule : rflw_port_ctl

// *** verilog/rflw_top.sv ***
// Receive FIFO low watermark release block for ports 1 to 3.
// Holds the release thresholds, drives per-port flow-control requests.
// Assumes register strobes, occupancy and high thresholds come from
// logic on the same core clock; no synchronisers are needed.

// Functional notes
// RL1 - Threshold counts eight-byte FIFO locations
// RL2 - Release flow control below low watermark
// RL3 - 12-bit field, reset 0x072, upper zero
// RL4 - Software keeps low below high watermark
// RL5 - Separate registers at 0x58B, 0x58C, 0x58D
// RL6 - Raise flow control above high watermark
// RL7 - Hold request between thresholds, hysteresis
module rflw_top
(
  // Clock and reset
  input  wire logic                                           clock,
  input  wire logic                                           reset,
  // Register port
  input  wire logic [rflw_pkg::ADDR_W-1:0]                    reg_addr,
  input  wire logic [rflw_pkg::DATA_W-1:0]                    reg_wdata,
  input  wire logic                                           reg_write,
  input  wire logic                                           reg_read,
  output logic      [rflw_pkg::DATA_W-1:0]                    reg_rdata,
  // Receive FIFO occupancy, one entry per port, in locations
  input  wire logic [rflw_pkg::NUM_PORTS-1:0][rflw_pkg::FILL_W-1:0] fill_level,
  // High watermarks from the flow-control unit
  input  wire logic [rflw_pkg::NUM_PORTS-1:0][rflw_pkg::THR_W-1:0]  high_thr,
  // Flow-control requests, index 0 is port 1
  output logic      [rflw_pkg::NUM_PORTS-1:0]                 flow_req
);

  // Threshold register index for a port position
  function automatic logic [rflw_pkg::ADDR_W-1:0] thr_index(input int unsigned port);
    logic [rflw_pkg::ADDR_W-1:0] idx;
    idx = rflw_pkg::RX_RELEASE_THRESHOLD_PORT1;
    case (port)
      0:       idx = rflw_pkg::RX_RELEASE_THRESHOLD_PORT1;
      1:       idx = rflw_pkg::RX_RELEASE_THRESHOLD_PORT2;
      2:       idx = rflw_pkg::RX_RELEASE_THRESHOLD_PORT3;
      default: idx = rflw_pkg::RX_RELEASE_THRESHOLD_PORT1;
    endcase
    return idx;
  endfunction : thr_index

  // Address decode shared by the write and read paths
  function automatic logic thr_hit(input logic [rflw_pkg::ADDR_W-1:0] addr,
                                   input int unsigned                 port);
    return (addr == thr_index(port));
  endfunction : thr_hit

  logic [rflw_pkg::NUM_PORTS-1:0][rflw_pkg::THR_W-1:0] thr_q;
  logic [rflw_pkg::NUM_PORTS-1:0][rflw_pkg::THR_W-1:0] thr_d;
  logic [rflw_pkg::DATA_W-1:0]                         rdata_q;
  logic [rflw_pkg::DATA_W-1:0]                         rdata_d;
  logic [rflw_pkg::NUM_PORTS-1:0]                      req_w;
  logic [rflw_pkg::NUM_PORTS-1:0]                      req_q;

  // Threshold next values: a write to a port's own index loads it
  always_comb
  begin
    thr_d = thr_q;
    for (int unsigned p = 0; p < rflw_pkg::NUM_PORTS; p++)
    begin
      if (reg_write && thr_hit(reg_addr, p))  // [RL5]
      begin
        thr_d[p] = reg_wdata[rflw_pkg::THR_MSB:rflw_pkg::THR_LSB];  // [RL3]
      end
    end
  end

  // Threshold registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      for (int unsigned p = 0; p < rflw_pkg::NUM_PORTS; p++)
      begin
        thr_q[p] <= rflw_pkg::THR_RESET;  // [RL3]
      end
    end
    else
    begin
      thr_q <= thr_d;
    end
  end

  // Read data: valid only in the cycle after the read strobe
  always_comb
  begin
    rdata_d = '0;
    if (reg_read)
    begin
      for (int unsigned p = 0; p < rflw_pkg::NUM_PORTS; p++)
      begin
        if (thr_hit(reg_addr, p))
        begin
          // Bits above the field read as zero
          rdata_d[rflw_pkg::THR_MSB:rflw_pkg::THR_LSB] = thr_q[p];  // [RL3]
        end
      end
      if (reg_addr == rflw_pkg::RX_FLOW_STATUS)
      begin
        rdata_d[rflw_pkg::STATUS_LSB +: rflw_pkg::NUM_PORTS] = req_q;
      end
    end
  end

  // Read data register
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // One hysteresis controller per port; software must keep low below
  // high, otherwise the raise condition takes priority
  for (genvar g = 0; g < rflw_pkg::NUM_PORTS; g++)
  begin : g_port
    rflw_port_ctl u_ctl
    (
      .clock      (clock),
      .reset      (reset),
      .fill_level (fill_level[g]),
      .low_thr    (thr_q[g]),
      .high_thr   (high_thr[g]),
      .flow_req   (req_w[g])
    );
  end

  // Request already comes from a flop inside each controller
  assign req_q    = req_w;
  assign flow_req = req_q;  // [RL2]

endmodule : rflw_top
